// ===== hdl/tlrc_pkg.sv
// Package of constants for the transceiver lane reset control block.
// Assumes a single 20 MHz clock and an Avalon-MM register slave.
`default_nettype none

package tlrc_pkg;

    // ------------------------------------------------------------------
    // Register word offsets (byte addresses, one aligned word each).
    // ------------------------------------------------------------------
    localparam logic [7:0] TLRC_OFF_LANE_RESET   = 8'h00;
    localparam logic [7:0] TLRC_OFF_CODING_CFG   = 8'h04;
    localparam logic [7:0] TLRC_OFF_SOFT_RESET   = 8'h08;
    localparam logic [7:0] TLRC_OFF_CLK_SELECT   = 8'h0c;
    localparam logic [7:0] TLRC_OFF_STATUS       = 8'h10;

    // ------------------------------------------------------------------
    // Analog lane component reset bit positions.
    // ------------------------------------------------------------------
    localparam int TLRC_PMA_SER    = 0;
    localparam int TLRC_PMA_DES    = 1;
    localparam int TLRC_PMA_DFE    = 2;
    localparam int TLRC_PMA_EYE    = 3;
    localparam int TLRC_PMA_LBFIFO = 4;
    localparam int TLRC_PMA_ANALOG = 5;
    localparam int TLRC_PMA_PLL0   = 6;
    localparam int TLRC_PMA_PLL1   = 7;
    localparam int TLRC_PMA_BITS   = 8;

    // ------------------------------------------------------------------
    // Coding configuration bit positions and reset values.
    // ------------------------------------------------------------------
    localparam int TLRC_CFG_MODE_RX      = 0;
    localparam int TLRC_CFG_MODE_TX      = 1;
    localparam int TLRC_CFG_8B10B        = 2;
    localparam int TLRC_CFG_CDR_RST_RX   = 3;
    localparam int TLRC_CFG_TX_AUTO      = 4;
    localparam int TLRC_CFG_BITS         = 5;
    // Default: reset acts on receive only, 8b10b, CDR unlock clears receive, auto tx reset on.
    localparam logic [4:0] TLRC_CFG_RESET = 5'h1d;

    // Soft reset register bits.
    localparam int TLRC_SOFT_TX = 0;
    localparam int TLRC_SOFT_RX = 1;

    // Transmit clock selection encoding.
    localparam logic [2:0] TLRC_DIV_1  = 3'h0;
    localparam logic [2:0] TLRC_DIV_2  = 3'h1;
    localparam logic [2:0] TLRC_DIV_4  = 3'h2;
    localparam logic [2:0] TLRC_DIV_8  = 3'h3;
    localparam logic [2:0] TLRC_DIV_11 = 3'h4;

    // Cycles for which the transmit path is held quiet while flushing.
    localparam int TLRC_FLUSH_CYCLES = 16;

endpackage : tlrc_pkg

`default_nettype wire

// ===== hdl/tlrc_rst_sync.sv
// Reset synchroniser: asynchronous assertion, two-stage synchronous release.
// Assumes the clock is the one of the domain whose reset is released.
`default_nettype none

module tlrc_rst_sync (
    input  wire logic clk,
    input  wire logic arst_n,
    output logic      srst_n
);

    logic meta_q;

    // Assertion bypasses the stages; release walks through both.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 1'b0;
            srst_n <= 1'b0;
        end else begin
            meta_q <= 1'b1;
            srst_n <= meta_q;
        end
    end

endmodule : tlrc_rst_sync

`default_nettype wire

// ===== hdl/tlrc_clk_div.sv
// Per-lane transmit clock enable generator dividing a selected base rate.
// Assumes base rate ticks arrive as one-cycle strobes on the system clock.
`default_nettype none

module tlrc_clk_div
    import tlrc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       base_tick,
    input  wire logic [2:0] div_sel,
    output logic            div_tick
);

    logic [3:0] cnt_q;
    logic [3:0] limit;

    // Terminal count for the chosen divider.
    always_comb begin
        case (div_sel)
            TLRC_DIV_2:  limit = 4'h1;
            TLRC_DIV_4:  limit = 4'h3;
            TLRC_DIV_8:  limit = 4'h7;
            TLRC_DIV_11: limit = 4'ha;
            default:     limit = 4'h0;
        endcase
    end

    // Count base ticks and emit one tick per divided period.
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q    <= 4'h0;
            div_tick <= 1'b0;
        end else begin
            div_tick <= 1'b0;
            if (base_tick) begin
                if (cnt_q >= limit) begin
                    cnt_q    <= 4'h0;
                    div_tick <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end

endmodule : tlrc_clk_div

`default_nettype wire

// ===== hdl/tlrc_top.sv
// Transceiver lane reset control: reset partitions, soft resets and tx clock select.
// Assumes 20 MHz clk, synchronous rst, Avalon-MM master on the register port.
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
//
// Chosen here: the Avalon-MM slave port and the register addresses.
`default_nettype none

module tlrc_top
    import tlrc_pkg::*;
#(
    parameter int LANES = 4
) (
    input  wire logic               clk,
    input  wire logic               rst,
    // Avalon-MM slave.
    input  wire logic [7:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    // Lane reset inputs.
    input  wire logic               analog_lane_reset_n,
    input  wire logic               coding_layer_reset_n,
    // Transmit PLL and receive status, receive clock and transmit serial data.
    input  wire logic [1:0]         transmit_pll_lock,
    input  wire logic [1:0]         pll_base_tick,
    input  wire logic               receive_clock_recovery_lock,
    input  wire logic               rx_clk_src,
    input  wire logic               tx_serial_data,
    // Reset, gated clock, serial data and lane tick outputs to the lane sections.
    output logic [TLRC_PMA_BITS-1:0] pma_reset_out,
    output logic                    rx_coding_reset,
    output logic                    tx_coding_reset,
    output logic                    flywheel_fifo_reset,
    output logic                    align_restart,
    output logic                    rx_clk_gated,
    output logic                    tx_serial_out,
    output logic [LANES-1:0]        tx_lane_tick
);

    // ------------------------------------------------------------------
    // Reset synchronisation.
    // ------------------------------------------------------------------
    logic pma_sync_n;
    logic pcs_sync_n;

    // Asynchronous assertion, two-stage release per partition.
    tlrc_rst_sync u_pma_sync (
        .clk    (clk),
        .arst_n (analog_lane_reset_n),
        .srst_n (pma_sync_n)
    );

    tlrc_rst_sync u_pcs_sync (
        .clk    (clk),
        .arst_n (coding_layer_reset_n),
        .srst_n (pcs_sync_n)
    );

    // ------------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------------
    logic [TLRC_PMA_BITS-1:0] lane_reset_reg0_q;
    logic [TLRC_CFG_BITS-1:0] cfg_q;
    logic [1:0]               soft_q;
    logic [4*LANES-1:0]       clk_sel_q;
    logic                     cfg_done_q;
    logic                     bus_ack_q;

    function automatic logic [31:0] tlrc_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[8*i +: 8] = new_v[8*i +: 8];
        end
        return r;
    endfunction

    logic        wr_hit;
    logic [31:0] merged_lane;
    logic [31:0] merged_cfg;
    logic [31:0] merged_soft;
    logic [31:0] merged_sel;

    assign wr_hit      = avs_write && bus_ack_q; // Lands where waitrequest is low.
    assign merged_lane = tlrc_merge({24'h0, lane_reset_reg0_q}, avs_writedata, avs_byteenable);
    assign merged_cfg  = tlrc_merge({27'h0, cfg_q}, avs_writedata, avs_byteenable);
    assign merged_soft = tlrc_merge({30'h0, soft_q}, avs_writedata, avs_byteenable);
    assign merged_sel  = tlrc_merge({{(32-4*LANES){1'b0}}, clk_sel_q}, avs_writedata, avs_byteenable);

    // Waitrequest drops for one cycle: answer on the second edge of a request.
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_ack_q       <= 1'b0;
            avs_waitrequest <= 1'b1;
        end else begin
            bus_ack_q       <= (avs_read || avs_write) && !bus_ack_q;
            avs_waitrequest <= !((avs_read || avs_write) && !bus_ack_q);
        end
    end

    // Component reset register for the analog section and PLLs.
    always_ff @(posedge clk) begin
        if (rst) begin
            lane_reset_reg0_q <= '0;
        end else if (wr_hit && avs_address == TLRC_OFF_LANE_RESET) begin
            lane_reset_reg0_q <= merged_lane[TLRC_PMA_BITS-1:0];
        end
    end

    // Reset behaviour configuration; defaults loaded before PLL release.
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q <= TLRC_CFG_RESET;
        end else if (wr_hit && avs_address == TLRC_OFF_CODING_CFG) begin
            cfg_q <= merged_cfg[TLRC_CFG_BITS-1:0];
        end
    end

    // Configuration is marked complete one edge after reset release.
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_done_q <= 1'b0;
        end else begin
            cfg_done_q <= 1'b1;
        end
    end

    // Soft coding resets used around rate and divider changes.
    always_ff @(posedge clk) begin
        if (rst) begin
            soft_q <= 2'h0;
        end else if (wr_hit && avs_address == TLRC_OFF_SOFT_RESET) begin
            soft_q <= merged_soft[1:0];
        end
    end

    // Per-lane transmit clock selection: bit 3 PLL, bits 2:0 divider.
    always_ff @(posedge clk) begin
        if (rst) begin
            clk_sel_q <= '0;
        end else if (wr_hit && avs_address == TLRC_OFF_CLK_SELECT) begin
            clk_sel_q <= merged_sel[4*LANES-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Coding layer and analog reset decode.
    // ------------------------------------------------------------------
    logic [1:0] pll_lock_q;
    logic [1:0] lock_rise;
    logic       pcs_prev_q;
    logic       pcs_fall;
    logic       pcs_held;
    logic       cdr_lock_q;
    logic       cdr_unlock;
    logic       active_pll;
    logic       tx_req;
    logic       rx_req;
    logic [4:0] flush_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            pll_lock_q <= 2'h0;
            pcs_prev_q <= 1'b1;
            cdr_lock_q <= 1'b0;
        end else begin
            pll_lock_q <= transmit_pll_lock;
            pcs_prev_q <= pcs_sync_n;
            cdr_lock_q <= receive_clock_recovery_lock;
        end
    end

    assign active_pll = clk_sel_q[3];
    assign lock_rise  = transmit_pll_lock & ~pll_lock_q;
    assign pcs_fall   = pcs_prev_q && !pcs_sync_n;
    assign pcs_held   = !pcs_sync_n || pcs_fall;
    assign cdr_unlock = cdr_lock_q && !receive_clock_recovery_lock;

    // Receive reset follows the pin when mode includes receive.
    assign rx_req = (pcs_held && cfg_q[TLRC_CFG_MODE_RX]) || soft_q[TLRC_SOFT_RX] || !pma_sync_n
                    || (cdr_unlock && cfg_q[TLRC_CFG_CDR_RST_RX]);

    // Transmit reset from pin, soft bit, or PLL lock rising.
    assign tx_req = (pcs_held && cfg_q[TLRC_CFG_MODE_TX]) || soft_q[TLRC_SOFT_TX] || !pma_sync_n
                    || !cfg_done_q || (cfg_q[TLRC_CFG_TX_AUTO] && lock_rise[active_pll]);

    // Flush timer keeps the transmit path quiet after each request.
    always_ff @(posedge clk) begin
        if (rst) begin
            flush_q <= 5'(TLRC_FLUSH_CYCLES);
        end else if (tx_req) begin
            flush_q <= 5'(TLRC_FLUSH_CYCLES);
        end else if (flush_q != 5'h0) begin
            flush_q <= flush_q - 5'h1;
        end
    end

    // Transmit coding reset and quiet serial output.
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_coding_reset <= 1'b1;
            tx_serial_out   <= 1'b0;
        end else begin
            tx_coding_reset <= tx_req || (flush_q != 5'h0);
            tx_serial_out   <= (tx_req || flush_q != 5'h0) ? 1'b0 : tx_serial_data;
        end
    end

    // Receive coding reset, flywheel clear and clock stop.
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_coding_reset     <= 1'b1;
            flywheel_fifo_reset <= 1'b1;
            rx_clk_gated        <= 1'b0;
        end else begin
            rx_coding_reset     <= rx_req;
            flywheel_fifo_reset <= rx_req;
            rx_clk_gated        <= rx_req ? 1'b0 : rx_clk_src;
        end
    end

    // Alignment restart pulse in 8b10b mode only on a fresh reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            align_restart <= 1'b0;
        end else begin
            align_restart <= cfg_q[TLRC_CFG_8B10B] && rx_req && !rx_coding_reset;
        end
    end

    // Analog resets: pin clears every part, register picks parts.
    always_ff @(posedge clk) begin
        if (rst) begin
            pma_reset_out <= '1;
        end else begin
            pma_reset_out <= pma_sync_n ? lane_reset_reg0_q : '1;
        end
    end

    // ------------------------------------------------------------------
    // Per-lane transmit clock selection.
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic base;
            assign base = pll_base_tick[clk_sel_q[4*g+3]];
            // Divided tick per lane from its chosen PLL.
            tlrc_clk_div u_div (
                .clk       (clk),
                .rst       (rst),
                .base_tick (base),
                .div_sel   (clk_sel_q[4*g +: 3]),
                .div_tick  (tx_lane_tick[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read data.
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && !bus_ack_q) begin
            case (avs_address)
                TLRC_OFF_LANE_RESET: avs_readdata <= {24'h0, lane_reset_reg0_q};
                TLRC_OFF_CODING_CFG: avs_readdata <= {27'h0, cfg_q};
                TLRC_OFF_SOFT_RESET: avs_readdata <= {30'h0, soft_q};
                TLRC_OFF_CLK_SELECT: avs_readdata <= {{(32-4*LANES){1'b0}}, clk_sel_q};
                TLRC_OFF_STATUS:     avs_readdata <= {24'h0, pcs_sync_n, pma_sync_n, pll_lock_q,
                                                      cdr_lock_q, rx_coding_reset, tx_coding_reset,
                                                      (flush_q != 5'h0)};
                default:             avs_readdata <= 32'h0;
            endcase
        end
    end

endmodule : tlrc_top

`default_nettype wire

// ===== sim/tlrc_checker_assertions.sv
// Concurrent checks on the ports of the lane reset control top.
// Assumes one clock, synchronous active-high rst, bound into tlrc_top.
`default_nettype none

module tlrc_chk #(
    parameter int LANES = 4
) (
    input wire logic             clk,
    input wire logic             rst,
    input wire logic             avs_read,
    input wire logic             avs_write,
    input wire logic [7:0]       avs_address,
    input wire logic [31:0]      avs_readdata,
    input wire logic             avs_waitrequest,
    input wire logic             analog_lane_reset_n,
    input wire logic             coding_layer_reset_n,
    input wire logic [1:0]       transmit_pll_lock,
    input wire logic [7:0]       pma_reset_out,
    input wire logic             rx_coding_reset,
    input wire logic             tx_coding_reset,
    input wire logic             align_restart,
    input wire logic             rx_clk_gated,
    input wire logic             tx_serial_out,
    input wire logic [LANES-1:0] tx_lane_tick
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // Steps of the bus, pin release and lock sequences.
    // ------------------------------------------------------------------
    sequence s_req;
        $rose(avs_read) || $rose(avs_write);
    endsequence
    sequence s_pin_release;
        $rose(analog_lane_reset_n);
    endsequence
    sequence s_lock_rise;
        $rose(transmit_pll_lock[0]);
    endsequence

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    bus_answer_a: assert property (s_req |=> !avs_waitrequest)
        else $error("request not answered in the next cycle");
    ack_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer lasted more than one cycle");
    unmapped_zero_a: assert property (avs_read && !avs_waitrequest &&
        avs_address >= 8'h14 |-> avs_readdata == 32'h0)
        else $error("unmapped read returned data");
    pin_reset_a: assert property (!analog_lane_reset_n |=>
        &pma_reset_out && rx_coding_reset && tx_coding_reset)
        else $error("analog pin low did not reset all parts");
    sync_release_a: assert property (s_pin_release |-> (&pma_reset_out) [*2])
        else $error("analog release not delayed by the synchroniser");
    coding_pin_a: assert property (!coding_layer_reset_n |=> rx_coding_reset)
        else $error("coding pin low did not reset receive path");
    rx_clk_stop_a: assert property (rx_coding_reset && $past(rx_coding_reset) |-> !rx_clk_gated)
        else $error("receive clock toggles during receive reset");
    tx_quiet_a: assert property (tx_coding_reset && $past(tx_coding_reset) |-> !tx_serial_out)
        else $error("serial output toggles during transmit reset");
    align_pulse_a: assert property (align_restart |=> !align_restart)
        else $error("align restart longer than one cycle");
    lock_reset_a: assert property (s_lock_rise |-> ##[1:4] tx_coding_reset)
        else $error("no transmit reset after pll lock");
    lane_tick_c: cover property (tx_lane_tick[LANES-1]);
endmodule // tlrc_chk

bind tlrc_top tlrc_chk #(.LANES(LANES)) i_chk (.clk(clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_address(avs_address), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .analog_lane_reset_n(analog_lane_reset_n), .coding_layer_reset_n(coding_layer_reset_n),
    .transmit_pll_lock(transmit_pll_lock), .pma_reset_out(pma_reset_out), .rx_coding_reset(rx_coding_reset),
    .tx_coding_reset(tx_coding_reset), .align_restart(align_restart), .rx_clk_gated(rx_clk_gated),
    .tx_serial_out(tx_serial_out), .tx_lane_tick(tx_lane_tick));

`default_nettype wire

// ===== sim/tlrc_fabric_model.sv
// Far-side model: reference clock ticks and pll lock seen by the block.
// Assumes the bench asks for lock loss through lock_req.
`default_nettype none

module tlrc_fabric_model #(
    parameter int P0 = 3,
    parameter int P1 = 4
) (
    input  wire logic [1:0] lock_req,
    input  wire logic       clk,
    output logic [1:0]      pll_base_tick,
    output logic [1:0]      transmit_pll_lock,
    output logic            cdr_lock
);
    timeunit 1ns;
    timeprecision 1ns;
    int c0 = 0;
    int c1 = 0;

    initial begin
        pll_base_tick = 2'h0;
        transmit_pll_lock = 2'h3;
        cdr_lock = 1'b1;
    end

    // Ticks run free; lock drops only when the bench removes a reference.
    always @(posedge clk) begin
        c0 <= (c0 == P0 - 1) ? 0 : c0 + 1;
        c1 <= (c1 == P1 - 1) ? 0 : c1 + 1;
        pll_base_tick <= {c1 == 0, c0 == 0};
        transmit_pll_lock <= lock_req;
        cdr_lock <= &lock_req;
    end
endmodule // tlrc_fabric_model

`default_nettype wire

// ===== sim/tlrc_top_bench.sv
// Self-checking bench for the lane reset control top.
// Assumes a 20 MHz clock and the register map of the package.
`default_nettype none

module tlrc_top_bench
    import tlrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LANES = 4;
    localparam logic [31:0] MASK [5] = '{32'hff, 32'h1f, 32'h3, 32'hffff, 32'h0};
    localparam logic [4:0] CFGS [3] = '{5'h1d, 5'h1f, 5'h19};
    localparam logic [15:0] CLKS [2] = '{16'h4b10, 16'h98c2};
    logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [3:0] avs_byteenable = 4'hf;
    logic avs_waitrequest, cdr_lock, rx_clk_src = 1'b0, tx_serial_data = 1'b0;
    logic analog_lane_reset_n = 1'b1, coding_layer_reset_n = 1'b1;
    logic [1:0] lock_req = 2'h3, transmit_pll_lock, pll_base_tick;
    logic [TLRC_PMA_BITS-1:0] pma_reset_out;
    logic rx_coding_reset, tx_coding_reset, flywheel_fifo_reset, align_restart, rx_clk_gated, tx_serial_out;
    logic [LANES-1:0] tx_lane_tick;
    logic [31:0] mdl [5];
    int num_errors = 0, cmp_count = 0, align_cnt = 0, lane_cnt [LANES], base_cnt [2];

    always #25 clk = ~clk;

    tlrc_fabric_model i_far (.lock_req(lock_req), .clk(clk), .pll_base_tick(pll_base_tick),
        .transmit_pll_lock(transmit_pll_lock), .cdr_lock(cdr_lock));

    tlrc_top #(.LANES(LANES)) i_dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .analog_lane_reset_n(analog_lane_reset_n),
        .coding_layer_reset_n(coding_layer_reset_n), .transmit_pll_lock(transmit_pll_lock),
        .pll_base_tick(pll_base_tick), .receive_clock_recovery_lock(cdr_lock), .rx_clk_src(rx_clk_src),
        .tx_serial_data(tx_serial_data), .pma_reset_out(pma_reset_out), .rx_coding_reset(rx_coding_reset),
        .tx_coding_reset(tx_coding_reset), .flywheel_fifo_reset(flywheel_fifo_reset),
        .align_restart(align_restart), .rx_clk_gated(rx_clk_gated), .tx_serial_out(tx_serial_out),
        .tx_lane_tick(tx_lane_tick));

    // Random serial data and free-running event counters.
    always @(posedge clk) begin
        tx_serial_data <= 1'($urandom);
        rx_clk_src <= 1'($urandom);
        align_cnt <= align_cnt + int'(align_restart);
        for (int l = 0; l < LANES; l++) lane_cnt[l] <= lane_cnt[l] + int'(tx_lane_tick[l]);
        for (int p = 0; p < 2; p++) base_cnt[p] <= base_cnt[p] + int'(pll_base_tick[p]);
    end

    // ------------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------------
    task automatic close_out();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One Avalon-MM transfer; holds the request until waitrequest is sampled low.
    task automatic bus(input logic wr_n, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        int i;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr_n;
        avs_read <= !wr_n;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (i == 20) begin
            num_errors++;
            close_out();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        bus(1'b1, a, d, be);
        if (a < 8'h10) begin
            for (int b = 0; b < 4; b++) if (be[b]) mdl[a[4:2]][8*b+:8] = d[8*b+:8];
            mdl[a[4:2]] &= MASK[a[4:2]];
        end
    endtask

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0, 4'hf);
        check("readdata", q, (a < 8'h10) ? mdl[a[4:2]] : 32'h0);
    endtask

    task automatic wait_on(input int w, input logic v);
        int i;
        for (i = 0; i < 80 && ((w == 0) ? tx_coding_reset : rx_coding_reset) !== v; i++) @(posedge clk);
        if (i == 80) begin
            num_errors++;
            close_out();
        end
    endtask

    function automatic int div_of(input logic [2:0] c);
        case (c)
            TLRC_DIV_2: return 2;
            TLRC_DIV_4: return 4;
            TLRC_DIV_8: return 8;
            TLRC_DIV_11: return 11;
            default: return 1;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        int b0 [2], l0 [LANES], a0, e, s, p;
        void'($urandom(32'he208cf27));
        foreach (mdl[i]) mdl[i] = 32'h0;
        foreach (lane_cnt[i]) lane_cnt[i] = 0;
        base_cnt = '{0, 0};
        mdl[1] = 32'h1d;
        cyc(2);
        check("pma_in_rst", pma_reset_out, 32'hff);
        rst <= 1'b0;
        wait_on(0, 1'b0);
        rd(TLRC_OFF_CODING_CFG);
        for (int k = 0; k < 4; k++) begin
            wr(TLRC_OFF_LANE_RESET, $urandom, 4'($urandom));
            rd(TLRC_OFF_LANE_RESET);
        end
        cyc(2);
        check("pma_reg", pma_reset_out, mdl[0]);
        wr(8'h14, 32'hffffffff, 4'hf);
        rd(8'h14);
        wr(TLRC_OFF_LANE_RESET, 32'h0, 4'hf);
        wr(TLRC_OFF_SOFT_RESET, 32'h0, 4'hf);
        rd(TLRC_OFF_SOFT_RESET);
        wait_on(0, 1'b0);
        wait_on(1, 1'b0);
        @(posedge clk);
        analog_lane_reset_n <= 1'b0;
        cyc(2);
        check("pin_reset", {pma_reset_out, rx_coding_reset, tx_coding_reset}, 32'h3ff);
        analog_lane_reset_n <= 1'b1;
        cyc(2);
        check("pma_hold", pma_reset_out, 32'hff);
        cyc(4);
        check("pma_free", pma_reset_out, mdl[0]);
        wait_on(0, 1'b0);
        wait_on(1, 1'b0);
        // Coding pin under each mode: default, both paths, and 8b10b off.
        for (int m = 0; m < 3; m++) begin
            wr(TLRC_OFF_CODING_CFG, 32'(CFGS[m]), 4'hf);
            a0 = align_cnt;
            @(posedge clk);
            coding_layer_reset_n <= 1'b0;
            cyc(3);
            check("coding_pin", {rx_coding_reset, tx_coding_reset, rx_clk_gated},
                  {1'b1, CFGS[m][1], 1'b0});
            coding_layer_reset_n <= 1'b1;
            wait_on(1, 1'b0);
            wait_on(0, 1'b0);
            check("align_count", 32'(align_cnt - a0), 32'(CFGS[m][2]));
        end
        wr(TLRC_OFF_CODING_CFG, 32'h1d, 4'hf);
        wr(TLRC_OFF_SOFT_RESET, 32'h2, 4'hf);
        cyc(3);
        check("soft_rx", {rx_coding_reset, flywheel_fifo_reset, rx_clk_gated}, 32'h6);
        wr(TLRC_OFF_SOFT_RESET, 32'h0, 4'hf);
        wait_on(1, 1'b0);
        // Divider change inside a soft transmit reset, then count lane ticks.
        for (int c = 0; c < 2; c++) begin
            wr(TLRC_OFF_SOFT_RESET, 32'h1, 4'hf);
            cyc(3);
            check("tx_quiet", {tx_coding_reset, tx_serial_out}, 32'h2);
            wr(TLRC_OFF_CLK_SELECT, 32'(CLKS[c]), 4'h3);
            wr(TLRC_OFF_SOFT_RESET, 32'h0, 4'hf);
            rd(TLRC_OFF_CLK_SELECT);
            wait_on(0, 1'b0);
            cyc(20);
            b0 = base_cnt;
            l0 = lane_cnt;
            cyc(400);
            for (int l = 0; l < LANES; l++) begin
                p = int'(CLKS[c][4*l+3]);
                e = (base_cnt[p] - b0[p]) / div_of(CLKS[c][4*l+:3]);
                s = lane_cnt[l] - l0[l];
                check("lane_tick", 32'(s >= e - 1 && s <= e + 1), 32'h1);
            end
        end
        lock_req <= 2'h2;
        cyc(6);
        lock_req <= 2'h3;
        wait_on(0, 1'b1);
        wait_on(0, 1'b0);
        close_out();
    end
endmodule // tlrc_top_bench

`default_nettype wire
